//--- hw/pch_config_regs.sv
`include "pch_regs.svh"

module pch_config_regs #(
  parameter int          LEN_W      = 12,
  parameter logic [15:0] VENDOR_ID  = 16'h1234, // arbitrary value
  parameter logic [15:0] DEVICE_ID  = 16'h5678, // arbitrary value
  parameter logic [7:0]  REVISION   = 8'h01     // arbitrary value
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // configuration cycle pins, pci clock domain
  input  wire logic                  pci_clk,
  input  wire pch_pkg::pch_cfg_pins_t cfg_in,
  output logic                       cfg_ack,
  output logic [31:0]                cfg_rdata,
  // bus events from the pci engine
  input  wire pch_pkg::pch_events_t  ev_in,
  // master read command selection
  input  wire logic [LEN_W-1:0]      rd_len,
  output logic [3:0]                 rd_cmd,
  // memory window decode
  input  wire logic                  mem_valid,
  input  wire logic [31:0]           mem_addr,
  output logic                       mem_hit,
  // control seen by the pci engine
  output pch_pkg::pch_command_t      command,
  output logic [7:0]                 latency_timer,
  output logic [7:0]                 cache_line_size,
  output logic [1:0]                 devsel_timing
);

  //////////////////////////////////////////////////////////////////////////////

  localparam pch_pkg::pch_state_t ST_RST = '{
    phase:    pch_pkg::PH_IDLE,
    // sync stages start high so leaving reset never fakes a pci clock rise
    pclk_s1:  1'b1,
    pclk_s2:  1'b1,
    pclk_s3:  1'b1,
    devsel:   `PCH_DEVSEL_MEDIUM,
    cls:      `PCH_RST_CACHE_LINE,
    lt:       `PCH_RST_LATENCY,
    base:     `PCH_RST_WINDOW_BASE,
    int_line: `PCH_RST_INT_LINE,
    rd_cmd:   `PCH_CMD_MEM_READ,
    default:  '0
  };

  pch_pkg::pch_state_t st_q;
  pch_pkg::pch_state_t st_d;
  logic                pclk_rise;
  pch_pkg::pch_status_t sts_set;
  logic [LEN_W-1:0]    cls_wide;

  assign pclk_rise = st_q.pclk_s2 & ~st_q.pclk_s3;
  assign cls_wide  = LEN_W'(st_q.cls);

  //////////////////////////////////////////////////////////////////////////////
  // configuration read mux

  function automatic logic [31:0] read_word(input pch_pkg::pch_state_t s,
                                            input logic [7:0]           a);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case ({a[7:2], 2'b00})
      `PCH_OFF_IDENT:       w = {DEVICE_ID, VENDOR_ID};
      `PCH_OFF_CMD_STATUS: begin
        w[`PCH_ST_DPE_BIT]      = s.sts.dpe;
        w[`PCH_ST_SSE_BIT]      = s.sts.sse;
        w[`PCH_ST_RMA_BIT]      = s.sts.rma;
        w[`PCH_ST_RTA_BIT]      = s.sts.rta;
        w[`PCH_ST_STA_BIT]      = s.sts.sta;
        w[26:25]                = s.devsel;
        w[`PCH_ST_DPR_BIT]      = s.sts.data_parity_reported;
        w[23]                   = 1'b1;     // fast back-to-back capable
        w[21]                   = 1'b1;     // 66 MHz capable
        w[`PCH_CMD_SIGNALLED_SYSTEM_ERROR_EN_BIT] = s.cmd.signalled_system_error_en;
        w[`PCH_CMD_DETECTED_PARITY_ERROR_EN_BIT] = s.cmd.detected_parity_error_en;
        w[`PCH_CMD_MSTR_EN_BIT] = s.cmd.mstr_en;
        w[`PCH_CMD_MEM_EN_BIT]  = s.cmd.mem_en;
      end
      `PCH_OFF_REV_CLASS:   w = {`PCH_CLASS_BASE, `PCH_CLASS_SUB,
                                 `PCH_CLASS_PROG_IF, REVISION};
      `PCH_OFF_CLS_LT_HDR:  w = {8'h00, `PCH_MULTI_FUNCTION,
                                 `PCH_HEADER_LAYOUT,
                                 s.lt, s.cls};
      `PCH_OFF_WINDOW_BASE: w = {s.base, `PCH_BAR_LOW_BITS};
      `PCH_OFF_INTR_NEEDS:  w = {`PCH_MAXIMUM_LATENCY,
                                 `PCH_MINIMUM_GRANT,
                                 `PCH_INTERRUPT_PIN,
                                 s.int_line};
      default:              w = 32'h0000_0000;
    endcase
    return w;
  endfunction : read_word

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    pch_pkg::pch_status_t sts_clr;
    pch_pkg::pch_cfg_pins_t c;
    sts_clr = '0;
    c       = st_q.cfg_s2;
    st_d    = st_q;

    // both the pci clock and the pins come from outside: two flops for the pins, three on the clock for the edge
    st_d.pclk_s1 = pci_clk;
    st_d.pclk_s2 = st_q.pclk_s1;
    st_d.pclk_s3 = st_q.pclk_s2;
    st_d.cfg_s1  = cfg_in;
    st_d.cfg_s2  = st_q.cfg_s1;

    // request taken on a pci clock rise; handshake keeps it safe across domains
    unique case (st_q.phase)
      pch_pkg::PH_IDLE: begin
        if (pclk_rise && c.req && c.idsel) begin
          st_d.ack   = 1'b1;
          st_d.phase = pch_pkg::PH_ACK;
          st_d.rdata = read_word(st_q, c.addr);
          if (c.write) begin
            unique case ({c.addr[7:2], 2'b00})
              `PCH_OFF_CMD_STATUS: begin
                if (c.be[0]) begin
                  st_d.cmd.mem_en  = c.wdata[`PCH_CMD_MEM_EN_BIT];
                  st_d.cmd.mstr_en = c.wdata[`PCH_CMD_MSTR_EN_BIT];
                  st_d.cmd.detected_parity_error_en = c.wdata[`PCH_CMD_DETECTED_PARITY_ERROR_EN_BIT];
                end
                if (c.be[1]) begin
                  st_d.cmd.signalled_system_error_en = c.wdata[`PCH_CMD_SIGNALLED_SYSTEM_ERROR_EN_BIT];
                end
                // write-one-to-clear only
                if (c.be[3]) begin
                  sts_clr.dpe = c.wdata[`PCH_ST_DPE_BIT];
                  sts_clr.sse = c.wdata[`PCH_ST_SSE_BIT];
                  sts_clr.rma = c.wdata[`PCH_ST_RMA_BIT];
                  sts_clr.rta = c.wdata[`PCH_ST_RTA_BIT];
                  sts_clr.sta = c.wdata[`PCH_ST_STA_BIT];
                end
                if (c.be[2]) begin
                  sts_clr.data_parity_reported = c.wdata[`PCH_ST_DPR_BIT];
                end
              end
              `PCH_OFF_CLS_LT_HDR: begin
                if (c.be[0]) begin
                  st_d.cls = c.wdata[7:0];
                end
                if (c.be[1]) begin
                  st_d.lt = c.wdata[15:8];
                end
              end
              `PCH_OFF_WINDOW_BASE: begin
                if (c.be[1]) begin
                  st_d.base[2:0] = c.wdata[15:13];
                end
                if (c.be[2]) begin
                  st_d.base[10:3] = c.wdata[23:16];
                end
                if (c.be[3]) begin
                  st_d.base[18:11] = c.wdata[31:24];
                end
              end
              `PCH_OFF_INTR_NEEDS: begin
                if (c.be[0]) begin
                  st_d.int_line = c.wdata[7:0];
                end
              end
              default: ;
            endcase
          end
        end
      end
      pch_pkg::PH_ACK: begin
        if (!c.req) begin
          st_d.ack   = 1'b0;
          st_d.phase = pch_pkg::PH_IDLE;
        end
      end
    endcase

    // a set in the same cycle as a clear wins, so no event is lost
    st_d.sts = (st_q.sts & ~sts_clr) | sts_set;

    if (rd_len <= LEN_W'(1)) begin
      st_d.rd_cmd = `PCH_CMD_MEM_READ;
    end else if (rd_len <= cls_wide) begin
      st_d.rd_cmd = `PCH_CMD_MEM_READ_LN;
    end else begin
      st_d.rd_cmd = `PCH_CMD_MEM_READ_MUL;
    end

    // window is 8K, so only bits above 12 take part in the match
    st_d.mem_hit = mem_valid && st_q.cmd.mem_en
                   && (mem_addr[31:`PCH_WINDOW_LSB] == st_q.base);
    st_d.devsel  = `PCH_DEVSEL_MEDIUM;
  end

  // hardware status sources
  always_comb begin
    sts_set     = '0;
    sts_set.data_parity_reported = ev_in.init_parity && st_q.cmd.detected_parity_error_en;
    sts_set.sta = ev_in.tabort_sent;
    sts_set.rta = ev_in.tabort_rcvd;
    sts_set.rma = ev_in.mabort && !ev_in.special_cycle;
    sts_set.sse = ev_in.signalled_system_error_drive;
    sts_set.dpe = ev_in.parity_detected;
  end

  //////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign cfg_ack         = st_q.ack;
  assign cfg_rdata       = st_q.rdata;
  assign rd_cmd          = st_q.rd_cmd;
  assign mem_hit         = st_q.mem_hit;
  assign command         = st_q.cmd;
  assign latency_timer   = st_q.lt;
  assign cache_line_size = st_q.cls;
  assign devsel_timing   = st_q.devsel;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_DPR_SET: assert property (
    ev_in.init_parity && st_q.cmd.detected_parity_error_en |=> st_q.sts.data_parity_reported)
    else $error("parity reported bit not set");

  AST_DPR_OFF: assert property (
    !$past(st_q.sts.data_parity_reported) && !$past(ev_in.init_parity && st_q.cmd.detected_parity_error_en)
    |-> !st_q.sts.data_parity_reported)
    else $error("parity reported bit set without cause");

  AST_DEVSEL: assert property (
    ##1 devsel_timing == `PCH_DEVSEL_MEDIUM)
    else $error("devsel timing not medium");

  AST_STA_SET: assert property (
    ev_in.tabort_sent |=> st_q.sts.sta)
    else $error("signalled target abort not set");

  AST_RTA_SET: assert property (
    ev_in.tabort_rcvd |=> st_q.sts.rta)
    else $error("received target abort not set");

  AST_RMA_SPECIAL: assert property (
    ev_in.mabort && ev_in.special_cycle && !st_q.sts.rma
    |=> !st_q.sts.rma)
    else $error("master abort set during special cycle");

  AST_RMA_SET: assert property (
    ev_in.mabort && !ev_in.special_cycle |=> st_q.sts.rma)
    else $error("received master abort not set");

  AST_SSE_SET: assert property (
    ev_in.signalled_system_error_drive |=> st_q.sts.sse)
    else $error("signalled system error not set");

  AST_DPE_SET: assert property (
    ev_in.parity_detected |=> st_q.sts.dpe)
    else $error("detected parity error not set");

  AST_STICKY: assert property (
    st_q.sts.dpe && !(st_q.phase == pch_pkg::PH_IDLE && pclk_rise
      && st_q.cfg_s2.req && st_q.cfg_s2.idsel && st_q.cfg_s2.write)
    |=> st_q.sts.dpe)
    else $error("status bit lost without a host write");

  AST_RD_SINGLE: assert property (
    rd_len == LEN_W'(1) |=> rd_cmd == `PCH_CMD_MEM_READ)
    else $error("single dword read not memory read");

  AST_RD_MULTI: assert property (
    rd_len > cls_wide && rd_len > LEN_W'(1) && $stable(st_q.cls)
    |=> rd_cmd == `PCH_CMD_MEM_READ_MUL)
    else $error("long read not memory read multiple");

  AST_HIT_OFF: assert property (
    !st_q.cmd.mem_en |=> !mem_hit)
    else $error("window hit while memory space disabled");

  AST_ACK_IDSEL: assert property (
    $rose(cfg_ack) |-> $past(st_q.cfg_s2.idsel) && $past(pclk_rise))
    else $error("config answer without idsel");

  AST_BAR_LOW: assert property (
    $rose(cfg_ack) && $past(st_q.cfg_s2.addr[7:2]) == 6'h04
    |-> cfg_rdata[12:0] == 13'h0000)
    else $error("window base low bits not zero");

  AST_CLASS_RO: assert property (
    $rose(cfg_ack) && {$past(st_q.cfg_s2.addr[7:2]), 2'b00} == `PCH_OFF_REV_CLASS
    |-> cfg_rdata == {`PCH_CLASS_BASE, `PCH_CLASS_SUB, `PCH_CLASS_PROG_IF, REVISION})
    else $error("class or revision word wrong");

  AST_HDR_RO: assert property (
    $rose(cfg_ack) && {$past(st_q.cfg_s2.addr[7:2]), 2'b00} == `PCH_OFF_CLS_LT_HDR
    |-> cfg_rdata[23:16] == {`PCH_MULTI_FUNCTION, `PCH_HEADER_LAYOUT})
    else $error("header layout or multi-function flag wrong");

  AST_INTR_RO: assert property (
    $rose(cfg_ack) && {$past(st_q.cfg_s2.addr[7:2]), 2'b00} == `PCH_OFF_INTR_NEEDS
    |-> cfg_rdata[31:8] == {`PCH_MAXIMUM_LATENCY, `PCH_MINIMUM_GRANT, `PCH_INTERRUPT_PIN})
    else $error("interrupt pin or bus needs bytes wrong");

  AST_UNUSED_ZERO: assert property (
    $rose(cfg_ack) && $past(st_q.cfg_s2.addr[7:5]) != 3'h0
    && {$past(st_q.cfg_s2.addr[7:2]), 2'b00} != `PCH_OFF_INTR_NEEDS |-> cfg_rdata == 32'h0)
    else $error("unimplemented offset read not zero");

  AST_LT_HOLD: assert property (
    !(st_q.phase == pch_pkg::PH_IDLE && pclk_rise && st_q.cfg_s2.req
      && st_q.cfg_s2.idsel && st_q.cfg_s2.write) |=> $stable(latency_timer))
    else $error("latency timer changed without a host write");

endmodule : pch_config_regs

//--- common/pch_regs.svh
`ifndef PCH_REGS_SVH
`define PCH_REGS_SVH

// configuration header byte offsets
`define PCH_OFF_IDENT        8'h00
`define PCH_OFF_CMD_STATUS   8'h04
`define PCH_OFF_REV_CLASS    8'h08
`define PCH_OFF_CLS_LT_HDR   8'h0c
`define PCH_OFF_WINDOW_BASE  8'h10
`define PCH_OFF_INTR_NEEDS   8'h3c

// command field positions
`define PCH_CMD_MEM_EN_BIT   1
`define PCH_CMD_MSTR_EN_BIT  2
`define PCH_CMD_DETECTED_PARITY_ERROR_EN_BIT  6
`define PCH_CMD_SIGNALLED_SYSTEM_ERROR_EN_BIT  8

// status field positions
`define PCH_ST_DPR_BIT       24
`define PCH_ST_STA_BIT       27
`define PCH_ST_RTA_BIT       28
`define PCH_ST_RMA_BIT       29
`define PCH_ST_SSE_BIT       30
`define PCH_ST_DPE_BIT       31

// device select timing encodings
`define PCH_DEVSEL_FAST      2'h0
`define PCH_DEVSEL_MEDIUM    2'h1
`define PCH_DEVSEL_SLOW      2'h2

// fixed read-only values
`define PCH_CLASS_BASE       8'h02
`define PCH_CLASS_SUB        8'h80
`define PCH_CLASS_PROG_IF    8'h00
`define PCH_HEADER_LAYOUT    7'h00
`define PCH_MULTI_FUNCTION   1'h0
`define PCH_INTERRUPT_PIN    8'h01
`define PCH_MINIMUM_GRANT    8'h05
`define PCH_MAXIMUM_LATENCY  8'h0f
`define PCH_WINDOW_LSB       13
`define PCH_BAR_LOW_BITS     13'h0000

// reset values of writable fields
`define PCH_RST_CACHE_LINE   8'h00
`define PCH_RST_LATENCY      8'h00
`define PCH_RST_WINDOW_BASE  19'h00000
`define PCH_RST_INT_LINE     8'h00

// master read command codes
`define PCH_CMD_MEM_READ     4'h6
`define PCH_CMD_MEM_READ_MUL 4'hc
`define PCH_CMD_MEM_READ_LN  4'he

`endif

//--- common/pch_pkg.sv
package pch_pkg;

  typedef enum logic {PH_IDLE, PH_ACK} pch_phase_t;

  typedef struct packed {
    logic        idsel;
    logic        req;
    logic        write;
    logic [3:0]  be;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } pch_cfg_pins_t;

  typedef struct packed {
    logic init_parity;
    logic tabort_sent;
    logic tabort_rcvd;
    logic mabort;
    logic special_cycle;
    logic signalled_system_error_drive;
    logic parity_detected;
  } pch_events_t;

  typedef struct packed {
    logic mem_en;
    logic mstr_en;
    logic detected_parity_error_en;
    logic signalled_system_error_en;
  } pch_command_t;

  typedef struct packed {
    logic dpe;
    logic sse;
    logic rma;
    logic rta;
    logic sta;
    logic data_parity_reported;
  } pch_status_t;

  typedef struct packed {
    logic          pclk_s1;
    logic          pclk_s2;
    logic          pclk_s3;
    pch_cfg_pins_t cfg_s1;
    pch_cfg_pins_t cfg_s2;
    pch_phase_t    phase;
    logic          ack;
    logic [31:0]   rdata;
    pch_command_t  cmd;
    pch_status_t   sts;
    logic [7:0]    cls;
    logic [7:0]    lt;
    logic [18:0]   base;
    logic [7:0]    int_line;
    logic [1:0]    devsel;
    logic [3:0]    rd_cmd;
    logic          mem_hit;
  } pch_state_t;

endpackage : pch_pkg

//--- tb/pch_host_model.sv
`include "pch_regs.svh"

module pch_host_model (
  // clocks
  input  wire logic                    ref_clk,
  output logic                         pci_clk,
  // configuration pins
  output pch_pkg::pch_cfg_pins_t       cfg_in,
  input  wire logic                    cfg_ack,
  input  wire logic [31:0]             cfg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // byte lanes of the next access; the bench narrows them for lane tests
  logic [3:0] lanes = 4'hf;

  initial begin
    pci_clk = 1'b0;
    cfg_in  = '0;
  end

  // bus clock runs free at one eighth of ref_clk, in a fixed phase to it
  always #40 pci_clk = ~pci_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic access(input logic sel, input logic wr, input logic [7:0] addr,
                        input logic [31:0] wdata, output logic [31:0] rdata,
                        output logic acked);
    acked = 1'b0;
    rdata = '0;
    @(posedge ref_clk);
    #1;
    // only a selected configuration cycle may reach the registers
    cfg_in = '{idsel: sel, req: 1'b1, write: wr, be: lanes, addr: addr, wdata: wdata};
    for (int i = 0; i < 40 && !acked; i++) begin
      @(posedge ref_clk);
      if (cfg_ack === 1'b1) begin
        acked = 1'b1;
        rdata = cfg_rdata;
      end
    end
    #1;
    // released write, address and data lines show the inverse, never a stale copy; idsel, req and lanes go low
    cfg_in = '{idsel: 1'b0, req: 1'b0, write: ~wr, be: 4'h0, addr: ~addr, wdata: ~wdata};
    for (int i = 0; i < 40 && cfg_ack !== 1'b0; i++) begin
      @(posedge ref_clk);
    end
  endtask : access

  // ones in, read back, lowest one above the config bits is the size
  task automatic size_window(output logic [31:0] size);
    logic [31:0] rd;
    logic [31:0] v;
    logic        ok;
    access(1'b1, 1'b1, `PCH_OFF_WINDOW_BASE, 32'hffff_ffff, rd, ok);
    access(1'b1, 1'b0, `PCH_OFF_WINDOW_BASE, 32'h0000_0000, rd, ok);
    v    = rd & 32'hffff_fff0;
    size = v & (~v + 32'h1);
  endtask : size_window

endmodule : pch_host_model

//--- tb/pch_config_regs_bench.sv
`include "pch_regs.svh"

module pch_config_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [15:0] VEND = 16'h0abc; // arbitrary value
  localparam logic [15:0] DEV  = 16'h0def; // arbitrary value
  localparam logic [7:0]  REV  = 8'h3c;    // arbitrary value
  localparam logic [31:0] ST0  = 32'h02a0_0000;
  localparam logic [31:0] CLS  = {`PCH_CLASS_BASE, 8'h80, 8'h00, REV};
  localparam logic [6:0]  EV_TAB [8] = '{7'h40, 7'h40, 7'h20, 7'h10, 7'h08, 7'h0c, 7'h02, 7'h01};
  localparam logic [31:0] EV_CMD [8] = '{32'h146, 32'h106, 32'h146, 32'h146, 32'h146,
                                         32'h146, 32'h146, 32'h106};
  localparam logic [31:0] EV_EXP [8] = '{32'h0100_0000, 32'h0, 32'h0800_0000, 32'h1000_0000,
                                         32'h2000_0000, 32'h0, 32'h4000_0000, 32'h8000_0000};

  logic                   ref_clk;
  logic                   rst_n;
  logic                   pci_clk;
  pch_pkg::pch_cfg_pins_t cfg_in;
  logic                   cfg_ack;
  logic [31:0]            cfg_rdata;
  pch_pkg::pch_events_t   ev_in;
  logic [11:0]            rd_len;
  logic [3:0]             rd_cmd;
  logic                   mem_valid;
  logic [31:0]            mem_addr;
  logic                   mem_hit;
  pch_pkg::pch_command_t  command;
  logic [7:0]             latency_timer;
  logic [7:0]             cache_line_size;
  logic [1:0]             devsel_timing;
  int                     miscompares = 0;
  int                     samples_checked = 0;
  int                     cycles = 0;
  logic [31:0]            rd;
  logic                   ok;

  ////////////////////////////////////////////////////////////////////////////
  pch_config_regs #(.LEN_W(12), .VENDOR_ID(VEND), .DEVICE_ID(DEV), .REVISION(REV)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .pci_clk(pci_clk), .cfg_in(cfg_in),
    .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .ev_in(ev_in), .rd_len(rd_len),
    .rd_cmd(rd_cmd), .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_hit(mem_hit),
    .command(command), .latency_timer(latency_timer), .cache_line_size(cache_line_size),
    .devsel_timing(devsel_timing)
  );

  pch_host_model i_host (
    .ref_clk(ref_clk), .pci_clk(pci_clk), .cfg_in(cfg_in), .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata)
  );

  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  // whole run needs about a thousand cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic cfg_rd(input logic [7:0] addr, input logic [31:0] exp);
    i_host.access(1'b1, 1'b0, addr, 32'h0, rd, ok);
    check("read answered", {31'h0, ok}, 32'h1);
    check("config read", rd, exp);
  endtask : cfg_rd

  task automatic cfg_wr(input logic [7:0] addr, input logic [31:0] data);
    i_host.access(1'b1, 1'b1, addr, data, rd, ok);
    check("write answered", {31'h0, ok}, 32'h1);
  endtask : cfg_wr

  task automatic probe(input logic [31:0] addr, input logic [11:0] len, input logic hit,
                       input logic [3:0] cmd);
    @(posedge ref_clk);
    #1;
    mem_valid = 1'b1;
    mem_addr  = addr;
    rd_len    = len;
    @(posedge ref_clk);
    #1;
    mem_valid = 1'b0;
    check("window hit", {31'h0, mem_hit}, {31'h0, hit});
    check("read command", {28'h0, rd_cmd}, {28'h0, cmd});
  endtask : probe

  task automatic pulse(input logic [6:0] ev);
    @(posedge ref_clk);
    #1;
    ev_in = ev;
    @(posedge ref_clk);
    #1;
    ev_in = '0;
  endtask : pulse

  task automatic test_done();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n     = 1'b0;
    ev_in     = '0;
    rd_len    = '0;
    mem_valid = 1'b0;
    mem_addr  = '0;
    repeat (5) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    check("devsel", {30'h0, devsel_timing}, {30'h0, `PCH_DEVSEL_MEDIUM});
    cfg_rd(`PCH_OFF_IDENT, {DEV, VEND});
    cfg_rd(`PCH_OFF_CMD_STATUS, ST0);
    cfg_rd(`PCH_OFF_REV_CLASS, CLS);
    cfg_rd(`PCH_OFF_CLS_LT_HDR, 32'h0);
    cfg_rd(`PCH_OFF_WINDOW_BASE, 32'h0);
    cfg_rd(`PCH_OFF_INTR_NEEDS, 32'h0f05_0100);
    cfg_wr(`PCH_OFF_REV_CLASS, 32'hffff_ffff);
    cfg_rd(`PCH_OFF_REV_CLASS, CLS);
    cfg_wr(8'h20, 32'hffff_ffff);
    cfg_rd(8'h20, 32'h0);
    cfg_wr(`PCH_OFF_CLS_LT_HDR, 32'hffff_ffff);
    cfg_rd(`PCH_OFF_CLS_LT_HDR, 32'h0000_ffff);
    check("latency timer", {24'h0, latency_timer}, 32'hff);
    cfg_wr(`PCH_OFF_INTR_NEEDS, 32'hffff_ffff);
    cfg_rd(`PCH_OFF_INTR_NEEDS, 32'h0f05_01ff);
    // unselected request: never answered, nothing stored
    i_host.access(1'b0, 1'b1, `PCH_OFF_INTR_NEEDS, 32'h0, rd, ok);
    check("unselected answer", {31'h0, ok}, 32'h0);
    cfg_rd(`PCH_OFF_INTR_NEEDS, 32'h0f05_01ff);
    i_host.size_window(rd);
    check("window size", rd, 32'h0000_2000);
    cfg_rd(`PCH_OFF_WINDOW_BASE, 32'hffff_e000);
    cfg_wr(`PCH_OFF_WINDOW_BASE, 32'ha000_2fff);
    cfg_rd(`PCH_OFF_WINDOW_BASE, 32'ha000_2000);
    cfg_wr(`PCH_OFF_CLS_LT_HDR, 32'h0000_0008);
    check("cache line", {24'h0, cache_line_size}, 32'h8);
    // one lane only: latency timer moves, cache line size stays
    i_host.lanes = 4'h2;
    cfg_wr(`PCH_OFF_CLS_LT_HDR, 32'h0000_3377);
    i_host.lanes = 4'hf;
    cfg_rd(`PCH_OFF_CLS_LT_HDR, 32'h0000_3308);
    cfg_wr(`PCH_OFF_CMD_STATUS, 32'h0000_0146);
    check("command", {28'h0, command}, 32'hf);
    probe(32'ha000_3ffc, 12'd0, 1'b1, `PCH_CMD_MEM_READ);
    probe(32'ha000_4000, 12'd1, 1'b0, `PCH_CMD_MEM_READ);
    probe(32'ha000_2000, 12'd8, 1'b1, `PCH_CMD_MEM_READ_LN);
    probe(32'h2000_2000, 12'd9, 1'b0, `PCH_CMD_MEM_READ_MUL);
    // zero write must not clear, ones clear, writes never set
    for (int i = 0; i < 8; i++) begin
      cfg_wr(`PCH_OFF_CMD_STATUS, EV_CMD[i]);
      pulse(EV_TAB[i]);
      cfg_rd(`PCH_OFF_CMD_STATUS, ST0 | EV_CMD[i] | EV_EXP[i]);
      cfg_wr(`PCH_OFF_CMD_STATUS, EV_CMD[i]);
      cfg_rd(`PCH_OFF_CMD_STATUS, ST0 | EV_CMD[i] | EV_EXP[i]);
      cfg_wr(`PCH_OFF_CMD_STATUS, 32'hffff_0000 | EV_CMD[i]);
      cfg_rd(`PCH_OFF_CMD_STATUS, ST0 | EV_CMD[i]);
    end
    cfg_wr(`PCH_OFF_CMD_STATUS, 32'h0);
    probe(32'ha000_2000, 12'd8, 1'b0, `PCH_CMD_MEM_READ_LN);
    // second reset mid-run puts writable fields back to zero
    cfg_wr(`PCH_OFF_CMD_STATUS, 32'h0000_0146);
    @(posedge ref_clk);
    #1;
    rst_n = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    cfg_rd(`PCH_OFF_CMD_STATUS, ST0);
    cfg_rd(`PCH_OFF_WINDOW_BASE, 32'h0);
    cfg_rd(`PCH_OFF_CLS_LT_HDR, 32'h0);
    cfg_rd(`PCH_OFF_INTR_NEEDS, 32'h0f05_0100);
    test_done();
  end

endmodule : pch_config_regs_bench
